/* File: src/ppc_pkg.sv */
// constants and register map for the port pin control block
// Contract
// - P3.6/P3.7 edge interrupts, polarity bits 2,3
// - active edge sets that pin's flag
// - flag requests interrupt only when enabled
// - weak pull-ups enabled after reset
// - global disable bit 7 kills all pull-ups
// - pull-up off where pin drives zero
// - port1 pin analog when mode bit 0
// - analog pin reads as zero
// - analog pin loses its pull-up
// - crossbar skips analog pins
// - low-port memif reserves P0.7, P0.6, muxed P0.5
// - memif owns pins during external data move
// - memif read disables data bus drivers (code does so only in multiplexed mode, on P0.4-P0.0)
package ppc_pkg;
  localparam logic [7:0] PPC_OFS_PIN_IRQ = 8'h00;
  localparam logic [7:0] PPC_OFS_CROSSBAR_CONFIG_TWO = 8'h04;
  localparam logic [7:0] PPC_OFS_P1_IN_MODE = 8'h08;
  localparam logic [7:0] PPC_OFS_P1_OUT_MODE = 8'h0C;
  localparam logic [7:0] PPC_OFS_P0_DATA = 8'h10;
  localparam logic [7:0] PPC_OFS_P1_DATA = 8'h14;
  localparam logic [7:0] PPC_OFS_P2_DATA = 8'h18;
  localparam logic [7:0] PPC_OFS_P3_DATA = 8'h1C;
  localparam logic [7:0] PPC_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] PPC_OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] PPC_OFS_MEMIF_CFG = 8'h28;
  localparam logic [7:0] PPC_OFS_P0_OUT_MODE = 8'h2C;
  // pin interrupt register fields
  localparam int PPC_BIT_E6_POL = 2;
  localparam int PPC_BIT_E7_POL = 3;
  localparam int PPC_BIT_E6_FLAG = 5;
  localparam int PPC_BIT_E7_FLAG = 6;
  // crossbar config two fields
  localparam int PPC_BIT_PU_OFF = 7;
  localparam int PPC_BIT_MEMIF_LOW = 1;
  // memif config: bit0 multiplexed mode
  localparam int PPC_BIT_MUXED = 0;
  // status/mask bits
  localparam int PPC_ST_E6 = 0;
  localparam int PPC_ST_E7 = 1;
  // P0 pins held by the memory interface strobes
  localparam int PPC_PIN_WR = 7;
  localparam int PPC_PIN_RD = 6;
  localparam int PPC_PIN_ALE = 5;
  localparam logic [7:0] PPC_RST_P1_IN_MODE = 8'hFF;
  localparam logic [7:0] PPC_RST_DATA = 8'hFF;
  localparam logic [7:0] PPC_RST_ZERO = 8'h00;
  localparam logic [1:0] PPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPC_HTRANS_NONSEQ = 2'h2;
endpackage

/* File: src/ppc_port_ctrl.sv */
// port pin control: edge interrupts, pull-ups, analog inputs, memif override
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic [7:0] p0_in,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p3_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe_n,
  output logic [7:0] p0_pullup_en,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe_n,
  output logic [7:0] p1_pullup_en,
  output logic [7:0] p2_pullup_en,
  output logic [7:0] p3_pullup_en,
  output logic [7:0] p1_digital_en,
  output logic [7:0] p1_xbar_skip,
  output logic [7:0] p0_xbar_reserved,
  input wire logic xbar_en_p0,
  input wire logic [7:0] xbar_p0_val,
  input wire logic [7:0] xbar_p0_drive,
  input wire logic memif_active,
  input wire logic memif_read,
  input wire logic [7:0] memif_p0_val,
  output logic irq
);
  import ppc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always OKAY
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [7:0] pin_irq_r, crossbar_config_two_r, p1_in_mode_r, p1_out_mode_r, p0_out_mode_r;
  logic [7:0] p0_data_r, p1_data_r, p2_data_r, p3_data_r;
  logic [1:0] stat_r, mask_r;
  logic muxed_r;
  logic p36_s1_r, p36_s2_r, p37_s1_r, p37_s2_r, p36_d_r, p37_d_r;
  logic edge6, edge7;
  logic wr_now;
  logic [7:0] wa;
  logic [31:0] rd_nxt;

  function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  wire addr_ok = hsel && hready && (htrans == PPC_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  assign wr_now = wr_pend_r;
  assign wa = addr_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= PPC_RESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= PPC_RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crossbar_config_two_r <= PPC_RST_ZERO;
      p1_in_mode_r <= PPC_RST_P1_IN_MODE;
      p1_out_mode_r <= PPC_RST_ZERO;
      p0_out_mode_r <= PPC_RST_ZERO;
      p0_data_r <= PPC_RST_DATA;
      p1_data_r <= PPC_RST_DATA;
      p2_data_r <= PPC_RST_DATA;
      p3_data_r <= PPC_RST_DATA;
      mask_r <= 2'h0;
      muxed_r <= 1'b0;
    end else if (wr_now) begin
      case (wa)
        PPC_OFS_CROSSBAR_CONFIG_TWO: crossbar_config_two_r <= hwdata[7:0];
        PPC_OFS_P1_IN_MODE: p1_in_mode_r <= hwdata[7:0];
        PPC_OFS_P1_OUT_MODE: p1_out_mode_r <= hwdata[7:0];
        PPC_OFS_P0_OUT_MODE: p0_out_mode_r <= hwdata[7:0];
        PPC_OFS_P0_DATA: p0_data_r <= hwdata[7:0];
        PPC_OFS_P1_DATA: p1_data_r <= hwdata[7:0];
        PPC_OFS_P2_DATA: p2_data_r <= hwdata[7:0];
        PPC_OFS_P3_DATA: p3_data_r <= hwdata[7:0];
        PPC_OFS_IRQ_MASK: mask_r <= hwdata[1:0];
        PPC_OFS_MEMIF_CFG: muxed_r <= hwdata[PPC_BIT_MUXED];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin edge detection on P3.6 / P3.7
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p36_s1_r <= 1'b1;
      p36_s2_r <= 1'b1;
      p37_s1_r <= 1'b1;
      p37_s2_r <= 1'b1;
      p36_d_r <= 1'b1;
      p37_d_r <= 1'b1;
    end else begin
      p36_s1_r <= p3_in[6];
      p36_s2_r <= p36_s1_r;
      p36_d_r <= p36_s2_r;
      p37_s1_r <= p3_in[7];
      p37_s2_r <= p37_s1_r;
      p37_d_r <= p37_s2_r;
    end
  end

  // polarity bit 1 selects rising edge
  assign edge6 = edge_hit(p36_d_r, p36_s2_r, pin_irq_r[PPC_BIT_E6_POL]);
  assign edge7 = edge_hit(p37_d_r, p37_s2_r, pin_irq_r[PPC_BIT_E7_POL]);

  // flags live in the pin interrupt register; writing 0 clears, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_irq_r <= PPC_RST_ZERO;
    end else begin
      if (wr_now && wa == PPC_OFS_PIN_IRQ) begin
        pin_irq_r[PPC_BIT_E6_POL] <= hwdata[PPC_BIT_E6_POL];
        pin_irq_r[PPC_BIT_E7_POL] <= hwdata[PPC_BIT_E7_POL];
        pin_irq_r[PPC_BIT_E6_FLAG] <= hwdata[PPC_BIT_E6_FLAG] | edge6;
        pin_irq_r[PPC_BIT_E7_FLAG] <= hwdata[PPC_BIT_E7_FLAG] | edge7;
      end else begin
        if (edge6) pin_irq_r[PPC_BIT_E6_FLAG] <= 1'b1;
        if (edge7) pin_irq_r[PPC_BIT_E7_FLAG] <= 1'b1;
      end
    end
  end

  // sticky status, write one to clear; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && edge6) || (i == 1 && edge7)) begin
          stat_r[i] <= 1'b1;
        end else if (wr_now && wa == PPC_OFS_IRQ_STAT && hwdata[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: pull-ups, analog mode, memory interface override
  logic [7:0] p0_drv, p0_val, p1_val, p1_drv;
  logic [7:0] rsv;
  logic memif_on;

  assign memif_on = crossbar_config_two_r[PPC_BIT_MEMIF_LOW] && memif_active;
  always_comb begin
    rsv = 8'h00;
    if (crossbar_config_two_r[PPC_BIT_MEMIF_LOW]) begin
      rsv[PPC_PIN_WR] = 1'b1;
      rsv[PPC_PIN_RD] = 1'b1;
      rsv[PPC_PIN_ALE] = muxed_r;
    end
  end

  // memif owns P0 values during an external move; a read in multiplexed mode releases P0.4-P0.0
  always_comb begin
    if (memif_on) begin
      p0_val = memif_p0_val;
      p0_drv = 8'hFF;
      if (memif_read && muxed_r) begin
        p0_drv[4:0] = 5'h00;
      end
    end else if (xbar_en_p0) begin
      p0_val = (xbar_p0_drive & ~rsv) & xbar_p0_val | ~(xbar_p0_drive & ~rsv) & p0_data_r;
      p0_drv = 8'hFF;
    end else begin
      p0_val = p0_data_r;
      p0_drv = 8'hFF;
    end
  end

  // analog pins keep their drivers; software is expected to park them high/open-drain
  assign p1_val = p1_data_r;
  assign p1_drv = 8'hFF;

  function automatic logic [7:0] drive_en(input logic [7:0] v, input logic [7:0] pp, input logic [7:0] d);
    drive_en = d & (pp | ~v);
  endfunction

  function automatic logic [7:0] pull_en(input logic [7:0] v, input logic [7:0] de, input logic off);
    pull_en = off ? 8'h00 : ~(de & ~v);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_out <= PPC_RST_DATA;
      p0_oe_n <= 8'hFF;
      p1_out <= PPC_RST_DATA;
      p1_oe_n <= 8'hFF;
      p0_pullup_en <= 8'hFF;
      p1_pullup_en <= 8'hFF;
      p2_pullup_en <= 8'hFF;
      p3_pullup_en <= 8'hFF;
      p1_digital_en <= 8'hFF;
      p1_xbar_skip <= 8'h00;
      p0_xbar_reserved <= 8'h00;
    end else begin
      p0_out <= p0_val;
      // memif keeps output mode; open-drain high stays undriven
      p0_oe_n <= ~drive_en(p0_val, p0_out_mode_r, p0_drv);
      p1_out <= p1_val;
      p1_oe_n <= ~drive_en(p1_val, p1_out_mode_r, p1_drv);
      p0_pullup_en <= pull_en(p0_val, drive_en(p0_val, p0_out_mode_r, p0_drv), crossbar_config_two_r[PPC_BIT_PU_OFF]);
      p1_pullup_en <= pull_en(p1_val, drive_en(p1_val, p1_out_mode_r, p1_drv), crossbar_config_two_r[PPC_BIT_PU_OFF])
                      & p1_in_mode_r;
      p2_pullup_en <= pull_en(p2_data_r, 8'hFF, crossbar_config_two_r[PPC_BIT_PU_OFF]);
      p3_pullup_en <= pull_en(p3_data_r, 8'hFF, crossbar_config_two_r[PPC_BIT_PU_OFF]);
      p1_digital_en <= p1_in_mode_r;
      p1_xbar_skip <= ~p1_in_mode_r;
      p0_xbar_reserved <= rsv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr[7:0])
      PPC_OFS_PIN_IRQ: rd_nxt[7:0] = pin_irq_r;
      PPC_OFS_CROSSBAR_CONFIG_TWO: rd_nxt[7:0] = crossbar_config_two_r;
      PPC_OFS_P1_IN_MODE: rd_nxt[7:0] = p1_in_mode_r;
      PPC_OFS_P1_OUT_MODE: rd_nxt[7:0] = p1_out_mode_r;
      PPC_OFS_P0_OUT_MODE: rd_nxt[7:0] = p0_out_mode_r;
      PPC_OFS_P0_DATA: rd_nxt[7:0] = p0_in;
      PPC_OFS_P1_DATA: rd_nxt[7:0] = p1_in & p1_in_mode_r;
      PPC_OFS_P2_DATA: rd_nxt[7:0] = p2_in;
      PPC_OFS_P3_DATA: rd_nxt[7:0] = p3_in;
      PPC_OFS_IRQ_STAT: rd_nxt[1:0] = stat_r;
      PPC_OFS_IRQ_MASK: rd_nxt[1:0] = mask_r;
      PPC_OFS_MEMIF_CFG: rd_nxt[0] = muxed_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: sim/ppc_port_ctrl_properties.sv */
// concurrent checks on the port pin control block ports
`timescale 1ns/1ps
`default_nettype none
module ppc_port_ctrl_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe_n,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p1_pullup_en,
  input wire logic [7:0] p1_digital_en,
  input wire logic [7:0] p1_xbar_skip,
  input wire logic [7:0] p0_xbar_reserved,
  input wire logic memif_active,
  input wire logic memif_read,
  input wire logic [7:0] memif_p0_val
);
  import ppc_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // two steady cycles so the registered pins have caught up
  sequence s_memif_hold;
    memif_active && p0_xbar_reserved[6] ##1 memif_active && $stable(memif_p0_val);
  endsequence
  sequence s_read_hold;
    memif_active && memif_read && p0_xbar_reserved[5] ##1 memif_active && memif_read;
  endsequence
  a_bus_okay: assert property (hreadyout && hresp == PPC_RESP_OKAY) else $error("bus answer not okay");
  a_drive0_nopull: assert property ((p1_pullup_en & ~p1_oe_n & ~p1_out) == 8'h00)
    else $error("pull-up on low driven pin");
  a_analog_nopull: assert property ((p1_pullup_en & ~p1_digital_en) == 8'h00)
    else $error("pull-up on analog pin");
  a_analog_skip: assert property (p1_xbar_skip == ~p1_digital_en) else $error("skip mismatch");
  a_resv_low: assert property (p0_xbar_reserved[4:0] == 5'h00) else $error("low pin reserved");
  a_resv_pair: assert property (p0_xbar_reserved[7] == p0_xbar_reserved[6] &&
    (!p0_xbar_reserved[5] || p0_xbar_reserved[6])) else $error("reserved set broken");
  a_memif_owns: assert property (s_memif_hold |-> p0_out[7:6] == memif_p0_val[7:6])
    else $error("strobe pins not memif");
  a_read_release: assert property (s_read_hold |-> p0_oe_n[4:0] == 5'h1F)
    else $error("data bus driven in read");
endmodule
`default_nettype wire

/* File: sim/ppc_pin_model.sv */
// pin model: device drive, outside drive, pull-up or floating line
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  logic [7:0] float_r = 8'h5A;
  // an unpulled, undriven line flips every cycle so no stale level reads back
  always_ff @(posedge clk) float_r <= ~float_r;
  assign pin = (~oe_n & out) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pullup_en | float_r));
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the port pin control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  import ppc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, mact = 1'b0, mrd = 1'b0, hreadyout, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, hresp;
  logic [7:0] p0_in, p1_in, p3_in, p0_out, p0_oe_n, p1_out, p1_oe_n, pu0, pu1, pu2, pu3, dig, skip, resv;
  logic [7:0] mval = 8'h00, p3_ext = 8'hFF, m;
  logic [7:0] xval = 8'h00, xdrv = 8'h00, p0_ext = 8'h00, p0_ext_en = 8'h00;
  logic [2:0] hsize = 3'h0;
  logic xen = 1'b0;
  wire logic hready;
  int fails = 0, compares = 0, pin, pol;
  assign hready = hreadyout;
  initial begin
    forever #4 hclk = ~hclk;
  end
  ppc_port_ctrl u_ppc_port_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .p0_in(p0_in), .p1_in(p1_in), .p2_in(p3_in), .p3_in(p3_in), .p0_out(p0_out),
    .p0_oe_n(p0_oe_n), .p0_pullup_en(pu0), .p1_out(p1_out), .p1_oe_n(p1_oe_n), .p1_pullup_en(pu1),
    .p2_pullup_en(pu2), .p3_pullup_en(pu3), .p1_digital_en(dig), .p1_xbar_skip(skip), .p0_xbar_reserved(resv),
    .xbar_en_p0(xen), .xbar_p0_val(xval), .xbar_p0_drive(xdrv), .memif_active(mact), .memif_read(mrd),
    .memif_p0_val(mval), .irq(irq));
  ppc_pin_model u_pins0 (.clk(hclk), .out(p0_out), .oe_n(p0_oe_n), .pullup_en(pu0), .ext(p0_ext),
    .ext_en(p0_ext_en), .pin(p0_in));
  ppc_pin_model u_pins1 (.clk(hclk), .out(p1_out), .oe_n(p1_oe_n), .pullup_en(pu1), .ext(8'h00),
    .ext_en(8'h00), .pin(p1_in));
  ppc_pin_model u_pins3 (.clk(hclk), .out(8'hFF), .oe_n(8'hFF), .pullup_en(pu3), .ext(p3_ext),
    .ext_en(8'hC0), .pin(p3_in));
  function automatic logic [7:0] pull_exp(input logic [7:0] digital, input logic [7:0] level);
    return digital & level;
  endfunction
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // a net cannot be passed by reference, so the watched signal is picked by a flag
  task automatic wait_sig(input bit on_irq);
    for (int n = 0; n < 30 && (on_irq ? irq : hready) !== 1'b1; n++) @(posedge hclk);
    if ((on_irq ? irq : hready) !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= PPC_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    tick(1);
    wait_sig(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    tick(1);
    wait_sig(1'b0);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd & msk)
  endtask
  initial begin
    void'($urandom(32'h07ED));
    tick(3);
    hresetn <= 1'b1;
    tick(1);
    `CHK("pullup p1", 8'hFF, pu1)
    `CHK("pullup p3", 8'hFF, pu3)
    rchk("p1 mode", PPC_OFS_P1_IN_MODE, 32'hFF, 32'hFF);
    bus(1'b1, PPC_OFS_CROSSBAR_CONFIG_TWO, 32'h80);
    tick(2);
    `CHK("global off", 8'h00, pu2)
    `CHK("global off p0", 8'h00, pu0)
    bus(1'b1, PPC_OFS_CROSSBAR_CONFIG_TWO, 32'h00);
    m = 8'($urandom);
    bus(1'b1, PPC_OFS_P1_OUT_MODE, 32'hFF);
    bus(1'b1, PPC_OFS_P1_DATA, {24'h0, m});
    tick(2);
    `CHK("pull drive0", pull_exp(8'hFF, m), pu1)
    `CHK("p1 level", m, p1_out)
    $display("test pull-ups done");
    bus(1'b1, PPC_OFS_P1_OUT_MODE, 32'h00);
    bus(1'b1, PPC_OFS_P1_DATA, 32'hFF);
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h00 : 8'($urandom);
      bus(1'b1, PPC_OFS_P1_IN_MODE, {24'h0, m});
      tick(2);
      `CHK("digital en", m, dig)
      `CHK("xbar skip", ~m, skip)
      `CHK("analog pull", pull_exp(m, 8'hFF), pu1)
      rchk("analog read", PPC_OFS_P1_DATA, {24'h0, m}, 32'hFF);
    end
    bus(1'b1, PPC_OFS_P1_IN_MODE, 32'hFF);
    $display("test analog done");
    bus(1'b1, PPC_OFS_IRQ_MASK, 32'h3);
    for (int k = 0; k < 4; k++) begin
      pin = 6 + k % 2;
      pol = k / 2;
      p3_ext[pin] <= pol[0];
      tick(8);
      bus(1'b1, PPC_OFS_PIN_IRQ, 32'(pol << (pin - 4)));
      bus(1'b1, PPC_OFS_IRQ_STAT, 32'h3);
      p3_ext[pin] <= ~pol[0];
      tick(8);
      rchk("wrong edge", PPC_OFS_IRQ_STAT, 32'h0, 32'h3);
      p3_ext[pin] <= pol[0];
      wait_sig(1'b1);
      rchk("status", PPC_OFS_IRQ_STAT, 32'(1 << (pin - 6)), 32'h3);
      rchk("flag", PPC_OFS_PIN_IRQ, 32'((pol << (pin - 4)) | (1 << (pin - 1))), 32'h6C);
      bus(1'b1, PPC_OFS_IRQ_STAT, 32'h3);
      bus(1'b1, PPC_OFS_PIN_IRQ, 32'(pol << (pin - 4)));
      tick(4);
      `CHK("irq clear", 1'b0, irq)
    end
    bus(1'b1, PPC_OFS_IRQ_MASK, 32'h0);
    p3_ext[7] <= 1'b0;
    tick(8);
    p3_ext[7] <= 1'b1;
    tick(10);
    `CHK("masked irq", 1'b0, irq)
    bus(1'b1, PPC_OFS_IRQ_MASK, 32'h3);
    wait_sig(1'b1);
    $display("test edge irq done");
    mval <= 8'($urandom);
    bus(1'b1, PPC_OFS_CROSSBAR_CONFIG_TWO, 32'h02);
    bus(1'b1, PPC_OFS_MEMIF_CFG, 32'h01);
    tick(2);
    `CHK("reserved mux", 8'hE0, resv)
    m = 8'($urandom);
    xen <= 1'b1;
    xdrv <= 8'hFF;
    xval <= m;
    tick(2);
    `CHK("xbar keeps resv", {3'b111, m[4:0]}, p0_out)
    mact <= 1'b1;
    mrd <= 1'b1;
    p0_ext <= ~m;
    p0_ext_en <= 8'h1F;
    tick(3);
    `CHK("memif out", mval[7:6], p0_out[7:6])
    `CHK("read release", 5'h1F, p0_oe_n[4:0])
    rchk("bus pins", PPC_OFS_P0_DATA, {27'h0, ~m[4:0]}, 32'h1F);
    mact <= 1'b0;
    xen <= 1'b0;
    p0_ext_en <= 8'h00;
    bus(1'b1, PPC_OFS_MEMIF_CFG, 32'h00);
    tick(2);
    `CHK("reserved plain", 8'hC0, resv)
    $display("test memif done");
    give_verdict();
  end
endmodule
bind ppc_port_ctrl ppc_port_ctrl_properties u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p1_out(p1_out), .p1_oe_n(p1_oe_n),
  .p1_pullup_en(p1_pullup_en), .p1_digital_en(p1_digital_en), .p1_xbar_skip(p1_xbar_skip),
  .p0_xbar_reserved(p0_xbar_reserved), .memif_active(memif_active), .memif_read(memif_read),
  .memif_p0_val(memif_p0_val));
`default_nettype wire
